// >>> shared/ccr_consts.vh
// Constants for the controller configuration register block.
// Assumes a 32-bit register port with word byte addresses.
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH

// Register byte addresses.
`define CCR_ADDR_CONFIG        8'h14
`define CCR_ADDR_STATUS        8'h1C
`define CCR_ADDR_LIMITS        8'h20
// Configuration field positions.
`define CCR_CQES_HI            23
`define CCR_CQES_LO            20
`define CCR_SQES_HI            19
`define CCR_SQES_LO            16
`define CCR_SHN_HI             15
`define CCR_SHN_LO             14
`define CCR_ARB_HI             13
`define CCR_ARB_LO             11
`define CCR_PAGE_HI            10
`define CCR_PAGE_LO            7
`define CCR_CSS_HI             6
`define CCR_CSS_LO             4
`define CCR_EN_BIT             0
// Writable bits of the configuration word; 31:24 and 3:1 read as zero.
`define CCR_CONFIG_WMASK       32'h00FFFFF1
`define CCR_CONFIG_RESET       32'h00000000
// Shutdown notice codes.
`define CCR_SHN_NONE           2'h0
`define CCR_SHN_NORMAL         2'h1
`define CCR_SHN_ABRUPT         2'h2
`define CCR_SHN_RSVD           2'h3
// Shutdown progress codes.
`define CCR_PROG_IDLE          2'h0
`define CCR_PROG_BUSY          2'h1
`define CCR_PROG_DONE          2'h2
// Arbitration codes.
`define CCR_ARB_RR             3'h0
`define CCR_ARB_WRR            3'h1
`define CCR_ARB_VENDOR         3'h7
// Page size base exponent.
`define CCR_PAGE_BASE          5'h0C
// Shutdown processing times in ns and cycles at 5 ns.
`define CCR_CLK_NS             5
`define CCR_NORMAL_NS          1000
`define CCR_ABRUPT_NS          20
// Cycle counts sized for the eight-bit timer: 1000 ns and 20 ns at 5 ns each.
`define CCR_NORMAL_CYC         8'hC8
`define CCR_ABRUPT_CYC         8'h04
// Default advertised entry size limits: cq min/max, sq min/max.
`define CCR_LIMITS_RESET       16'h4466

`endif

// >>> logic/ccr_shutdown_timer.v
// Down counter that times shutdown processing.
// Assumes one clock and synchronous active-high reset.
`default_nettype none

module ccr_shutdown_timer (
   input  wire        i_core_clk,
   input  wire        i_reset,
   input  wire        i_load,
   input  wire [7:0]  i_count,
   output reg         o_done
);
   reg [7:0] count_r;

   // Loading restarts the count, so a second notice shortens or lengthens it.
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         count_r <= 8'h00;
         o_done  <= 1'b0;
      end else if (i_load) begin
         count_r <= i_count;
         o_done  <= 1'b0;
      end else if (count_r != 8'h00) begin
         count_r <= count_r - 8'h01;
         o_done  <= (count_r == 8'h01);
      end else begin
         o_done  <= 1'b0;
      end
   end
endmodule // ccr_shutdown_timer

`default_nettype wire

// >>> logic/ccr_config_reg.v
// Controller configuration register with shutdown notice handling.
// Assumes a same-clock register port whose strobes are one cycle long.
//
// How it works
// R1 - Host sets selectors before enable bit.
// R2 - Completion entry size bits 23:20, reset zero.
// R3 - Submission entry size bits 19:16, reset zero.
// R4 - Host keeps entry sizes within advertised limits.
// R5 - Shutdown notice bits 15:14; 00b does nothing. Here a 00b write moves a done progress back to idle.
// R6 - Writing 01b starts normal shutdown processing.
// R7 - Abrupt notice processed as fast as possible.
// R8 - Host writes notice before power down.
// R9 - Host should notify before warm reboot.
// R10 - Completion reported in separate status register.
// R11 - Arbitration bits 13:11 decode RR, WRR, vendor.
// R12 - Page size is two to twelve plus field.
// R13 - Code 10b abrupt, 11b reserved no action.
// R14 - Bits 31:24 reserved, read zero.
//
// Register map on the byte-addressed register port.
// Address 0x14 holds the configuration word; bit 0 enables the controller.
// Address 0x1C is the status word; bits 3:2 report shutdown progress.
// Progress reads 0 when idle, 1 while busy and 2 once shutdown is done.
// Address 0x20 holds sixteen bits of advertised entry size limits.
// Every other address reads zero and drops writes.
//
// Timing on the register port.
// A write lands in the register at the edge that samples its strobe.
// A read answers in the cycle after its strobe and shows zero otherwise.
// Decoded outputs follow a configuration write two edges after the strobe.
// Shutdown progress turns busy two edges after the notice is written.
//
// Limitations.
// The entry size limits are advertised only; nothing here enforces them.
// Selectors are not locked while enabled, so software clears enable first.
// Normal and abrupt processing times are fixed counts, not real work.
// Enable is a plain stored bit; the queues behind it are outside this block.
//
// Our own choice: the address-and-strobe port.
`include "ccr_consts.vh"
`default_nettype none

module ccr_config_reg (
   input  wire        i_core_clk,
   input  wire        i_reset,
   input  wire [7:0]  i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [31:0] o_rdata,
   output reg         o_enable,
   output reg  [3:0]  o_completion_entry_size,
   output reg  [3:0]  o_submission_entry_size,
   output reg  [2:0]  o_command_set_select,
   output reg  [4:0]  o_page_shift,
   output reg         o_arb_round_robin,
   output reg         o_arb_weighted,
   output reg         o_arb_vendor,
   output reg         o_shutdown_active,
   output reg         o_shutdown_abrupt,
   output reg  [1:0]  o_shutdown_progress
);
   // Sequencer states; their codes double as the progress value software reads.
   localparam ST_IDLE = 2'b00;
   localparam ST_BUSY = 2'b01;
   localparam ST_DONE = 2'b10;

   // Register image, limits store and the sequencer's next-state terms.
   reg [31:0] config_r;
   reg [31:0] config_nxt;
   reg [15:0] limits_r;
   reg [1:0]  state_r;
   reg [1:0]  state_nxt;
   reg        abrupt_r;
   reg        abrupt_nxt;
   reg        load_r;
   reg        load_nxt;
   reg [7:0]  load_count_r;
   reg [7:0]  load_count_nxt;
   // Timer handshake and write decode.
   wire       timer_done;
   wire       wr_config;
   wire [1:0] new_shn;

   // Only a write to the configuration address can start or clear a shutdown.
   assign wr_config = i_wr && (i_addr == `CCR_ADDR_CONFIG);
   assign new_shn   = i_wdata[`CCR_SHN_HI:`CCR_SHN_LO];

   // Reserved bits are masked at write time, so they always read zero.
   // Masking at write time costs nothing on the read path.
   always @* begin
      config_nxt = config_r;
      if (wr_config) begin
         config_nxt = i_wdata & `CCR_CONFIG_WMASK; // R14 R2 R3 R5
      end
   end

   // Shutdown sequencing; abrupt notice uses the shorter count.
   // While busy, a 00b or repeated notice is ignored and processing runs to its end.
   // The timer is loaded one edge after the notice, which costs a cycle but keeps
   // the count register free of the write decode path.
   always @* begin
      state_nxt      = state_r;
      abrupt_nxt     = abrupt_r;
      load_nxt       = 1'b0;
      load_count_nxt = load_count_r;
      // Code 11b matches no branch, so a reserved notice leaves the state alone.
      case (state_r)
         ST_IDLE, ST_DONE: begin
            if (wr_config && new_shn == `CCR_SHN_NORMAL) begin
               state_nxt      = ST_BUSY; // R6
               abrupt_nxt     = 1'b0;
               load_nxt       = 1'b1;
               load_count_nxt = `CCR_NORMAL_CYC;
            end else if (wr_config && new_shn == `CCR_SHN_ABRUPT) begin
               state_nxt      = ST_BUSY; // R13
               abrupt_nxt     = 1'b1;
               load_nxt       = 1'b1;
               load_count_nxt = `CCR_ABRUPT_CYC; // R7
            end else if (wr_config && new_shn == `CCR_SHN_NONE) begin
               state_nxt = ST_IDLE; // R5
            end
         end
         ST_BUSY: begin
            // An abrupt notice during a normal shutdown cuts it short.
            if (wr_config && new_shn == `CCR_SHN_ABRUPT && !abrupt_r) begin
               abrupt_nxt     = 1'b1; // R7
               load_nxt       = 1'b1;
               load_count_nxt = `CCR_ABRUPT_CYC;
            end else if (timer_done) begin
               state_nxt = ST_DONE; // R10
            end
         end
         // An unused state code recovers to idle.
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Register state; reset returns the limits store to its advertised defaults.
   // The limits store takes only the low sixteen bits of a write.
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         config_r     <= `CCR_CONFIG_RESET;
         limits_r     <= `CCR_LIMITS_RESET;
         state_r      <= ST_IDLE;
         abrupt_r     <= 1'b0;
         load_r       <= 1'b0;
         load_count_r <= 8'h00;
      end else begin
         config_r     <= config_nxt;
         state_r      <= state_nxt;
         abrupt_r     <= abrupt_nxt;
         load_r       <= load_nxt;
         load_count_r <= load_count_nxt;
         // A write to the limits address never touches the configuration word.
         if (i_wr && i_addr == `CCR_ADDR_LIMITS) begin
            limits_r <= i_wdata[15:0];
         end
      end
   end

   // The timer runs the shutdown processing time; its done pulse is one cycle long,
   // which the sequencer sees while busy because nothing else can clear the state.
   ccr_shutdown_timer u_timer (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_load     (load_r),
      .i_count    (load_count_r),
      .o_done     (timer_done)
   );

   // Read port answers one cycle later; unmapped addresses read zero.
   // Zero outside the answer slot keeps a wired-or read bus above this block clean.
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_rdata <= 32'h00000000;
      end else if (i_rd) begin
         case (i_addr)
            `CCR_ADDR_CONFIG: o_rdata <= config_r; // R14
            `CCR_ADDR_STATUS: o_rdata <= {28'h0000000, state_r, 2'h0}; // R10
            `CCR_ADDR_LIMITS: o_rdata <= {16'h0000, limits_r};
            default:          o_rdata <= 32'h00000000;
         endcase
      end else begin
         o_rdata <= 32'h00000000;
      end
   end

   // Decoded configuration outputs, one cycle behind the register.
   // The extra register stage keeps every top-level output straight off a flip-flop.
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_enable                <= 1'b0;
         o_completion_entry_size <= 4'h0;
         o_submission_entry_size <= 4'h0;
         o_command_set_select    <= 3'h0;
         o_page_shift            <= `CCR_PAGE_BASE;
         o_arb_round_robin       <= 1'b1;
         o_arb_weighted          <= 1'b0;
         o_arb_vendor            <= 1'b0;
         o_shutdown_active       <= 1'b0;
         o_shutdown_abrupt       <= 1'b0;
         o_shutdown_progress     <= `CCR_PROG_IDLE;
      end else begin
         o_enable                <= config_r[`CCR_EN_BIT];
         o_completion_entry_size <= config_r[`CCR_CQES_HI:`CCR_CQES_LO]; // R2
         o_submission_entry_size <= config_r[`CCR_SQES_HI:`CCR_SQES_LO]; // R3
         o_command_set_select    <= config_r[`CCR_CSS_HI:`CCR_CSS_LO];
         // Page size shift fits in five bits since the field is at most 15.
         o_page_shift            <= `CCR_PAGE_BASE + {1'b0, config_r[`CCR_PAGE_HI:`CCR_PAGE_LO]}; // R12
         // Reserved arbitration codes leave all three decode outputs low.
         o_arb_round_robin       <= (config_r[`CCR_ARB_HI:`CCR_ARB_LO] == `CCR_ARB_RR); // R11
         o_arb_weighted          <= (config_r[`CCR_ARB_HI:`CCR_ARB_LO] == `CCR_ARB_WRR); // R11
         o_arb_vendor            <= (config_r[`CCR_ARB_HI:`CCR_ARB_LO] == `CCR_ARB_VENDOR); // R11
         // Shutdown status mirrors the sequencer one edge later.
         o_shutdown_active       <= (state_r == ST_BUSY);
         o_shutdown_abrupt       <= abrupt_r;
         o_shutdown_progress     <= state_r; // R10
      end
   end
endmodule // ccr_config_reg

`default_nettype wire

// >>> dv/ccr_config_reg_sva.sv
// Checker for the configuration register ports.
// Assumes one clock and that nothing is read while reset is high.
`include "ccr_consts.vh"
`default_nettype none
module ccr_config_reg_sva (
   input wire logic        i_core_clk,
   input wire logic        i_reset,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic [3:0]  o_completion_entry_size,
   input wire logic [3:0]  o_submission_entry_size,
   input wire logic [4:0]  o_page_shift,
   input wire logic        o_arb_round_robin,
   input wire logic        o_arb_weighted,
   input wire logic        o_arb_vendor,
   input wire logic        o_shutdown_active,
   input wire logic        o_shutdown_abrupt,
   input wire logic [1:0]  o_shutdown_progress
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   // A config write, its notice code and arbitration code; effects land two edges later.
   wire logic       wc;
   wire logic [1:0] sn;
   wire logic [2:0] ar;
   assign wc = i_wr && i_addr == `CCR_ADDR_CONFIG;
   assign sn = i_wdata[15:14];
   assign ar = i_wdata[13:11];
   AST_RD_ZERO: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside slot");
   AST_RSVD: assert property ($past(i_rd) |-> o_rdata[31:24] == 8'h0)
      else $error("reserved bits not zero");
   AST_CQES: assert property (wc |-> ##2 o_completion_entry_size == $past(i_wdata[23:20], 2))
      else $error("completion size wrong");
   AST_SQES: assert property (wc |-> ##2 o_submission_entry_size == $past(i_wdata[19:16], 2))
      else $error("submission size wrong");
   AST_PAGE: assert property (wc |-> ##2 o_page_shift == `CCR_PAGE_BASE + $past(i_wdata[10:7], 2))
      else $error("page shift wrong");
   AST_ARB: assert property (wc |-> ##2 {o_arb_round_robin, o_arb_weighted, o_arb_vendor} ==
      {$past(ar, 2) == 3'h0, $past(ar, 2) == 3'h1, $past(ar, 2) == 3'h7}) else $error("arbitration decode wrong");
   AST_NORM: assert property (wc && sn == 2'h1 |-> ##2 o_shutdown_active && !o_shutdown_abrupt)
      else $error("normal shutdown not started");
   AST_ABR: assert property (wc && sn == 2'h2 |-> ##2 o_shutdown_abrupt ##[1:8] o_shutdown_progress == 2'h2)
      else $error("abrupt shutdown slow");
   // A write one edge earlier may still start a shutdown, so it is excluded.
   AST_QUIET: assert property (wc && sn[0] == sn[1] && !o_shutdown_active && !$past(wc) |->
      ##2 !o_shutdown_active) else $error("idle notice acted");
   COV_NORM: cover property (wc && sn == 2'h1);
   COV_ABR: cover property (wc && sn == 2'h2);
   COV_RD: cover property ($past(i_rd) && o_rdata != 32'h0);
endmodule // ccr_config_reg_sva
bind ccr_config_reg ccr_config_reg_sva i_ccr_config_reg_sva (.i_core_clk, .i_reset, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .o_completion_entry_size, .o_submission_entry_size, .o_page_shift,
   .o_arb_round_robin, .o_arb_weighted, .o_arb_vendor, .o_shutdown_active, .o_shutdown_abrupt,
   .o_shutdown_progress);
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the configuration register block.
// Assumes the design and its constants header are on the include path.
`include "ccr_consts.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, wr, rd, en, rr, wt, vn, act, abr;
   logic [7:0]  a;
   logic [31:0] wd, q, rdv;
   logic [3:0]  cq, sq;
   logic [2:0]  cs;
   logic [4:0]  ps;
   logic [1:0]  pg;
   int          n_mismatch = 0;
   int          tests_run = 0;
   ccr_config_reg i_ccr_config_reg (.i_core_clk(clk), .i_reset(rst), .i_addr(a), .i_wdata(wd), .i_wr(wr),
      .i_rd(rd), .o_rdata(q), .o_enable(en), .o_completion_entry_size(cq), .o_submission_entry_size(sq),
      .o_command_set_select(cs), .o_page_shift(ps), .o_arb_round_robin(rr), .o_arb_weighted(wt),
      .o_arb_vendor(vn), .o_shutdown_active(act), .o_shutdown_abrupt(abr), .o_shutdown_progress(pg));
   // A 5 ns clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic wrr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      a <= ad; wd <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rdr(input logic [7:0] ad);
      @(posedge clk);
      a <= ad; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rdv = q;
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // Limits are opened first so all-ones entry sizes stay legal; selectors go in before enable.
   task automatic t_fields;
      wrr(`CCR_ADDR_LIMITS, 32'h00000F0F);
      rdr(`CCR_ADDR_LIMITS);
      chk(rdv, 32'h00000F0F, "limits write");
      wrr(`CCR_ADDR_CONFIG, 32'hFFFF3FFE);
      wrr(`CCR_ADDR_CONFIG, 32'hFFFF3FFF);
      rdr(`CCR_ADDR_CONFIG);
      chk(rdv, 32'h00FF3FF1, "config readback");
      settle;
      chk({cq, sq, cs, ps, en}, {4'hF, 4'hF, 3'h7, 5'h1B, 1'b1}, "field outputs");
      wrr(8'h18, 32'hFFFFFFFF);
      rdr(8'h18);
      chk(rdv, 32'h0, "unmapped read");
      wrr(`CCR_ADDR_CONFIG, 32'h00FF3FF0);
   endtask
   task automatic t_arb;
      logic [2:0] t [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
      for (int i = 0; i < 4; i++) begin
         wrr(`CCR_ADDR_CONFIG, {18'h0, t[i], 11'h0});
         settle;
         chk({rr, wt, vn}, {t[i] == 3'h0, t[i] == 3'h1, t[i] == 3'h7}, "arbitration");
      end
   endtask
   // Counts edges from the notice write until progress reports done.
   task automatic t_shut(input logic [1:0] c, input int lo, input int hi);
      int n;
      wrr(`CCR_ADDR_CONFIG, {16'h0, c, 14'h0});
      settle;
      n = 2;
      while (pg !== 2'h2 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      chk(n >= lo && n <= hi, 1'b1, "shutdown time");
      chk(abr, c == 2'h2, "abrupt flag");
      rdr(`CCR_ADDR_STATUS);
      chk(rdv[3:2], `CCR_PROG_DONE, "status progress");
   endtask
   task automatic give_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence: reset, then each scenario in turn.
   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; a = 8'h0; wd = 32'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdr(`CCR_ADDR_CONFIG);
      chk({rdv, ps, rr, wt, vn}, {32'h0, 5'h0C, 3'h4}, "reset values");
      rdr(`CCR_ADDR_LIMITS);
      chk(rdv, `CCR_LIMITS_RESET, "limits reset");
      t_fields;
      t_arb;
      t_shut(2'h1, 150, 260);
      wrr(`CCR_ADDR_CONFIG, 32'h0);
      settle;
      chk({act, pg}, 3'h0, "notice cleared");
      t_shut(2'h2, 2, 12);
      wrr(`CCR_ADDR_CONFIG, 32'h0000C000);
      settle;
      chk({act, pg}, 3'h2, "reserved notice");
      // An abrupt notice during a normal shutdown must cut it short.
      wrr(`CCR_ADDR_CONFIG, 32'h00004000);
      settle;
      chk({act, abr, pg}, 4'h9, "normal restarted");
      t_shut(2'h2, 2, 12);
      // Warm restart after the notice has been given.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdr(`CCR_ADDR_STATUS);
      chk({rdv, act, abr, pg, ps, rr}, {36'h0, 5'h0C, 1'b1}, "warm reset values");
      give_verdict;
   end
   // The run needs about 1.5 us; eight times that means a hang.
   initial begin
      #12000;
      n_mismatch++;
      give_verdict;
   end
endmodule // tb
`default_nettype wire
